/* shared/ceb_pkg.sv */
// ceb_pkg: constants for the configuration extension bus bridge
// assumes a single 10 MHz clock domain and a classic wishbone master
package ceb_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CEB_REG_CTRL = 8'h00;
	localparam logic [7:0] CEB_REG_PF_STD = 8'h04;
	localparam logic [7:0] CEB_REG_PF_EXT = 8'h08;
	localparam logic [7:0] CEB_REG_VF_STD = 8'h0c;
	localparam logic [7:0] CEB_REG_VF_EXT = 8'h10;
	localparam logic [7:0] CEB_REG_REQ = 8'h14;
	localparam logic [7:0] CEB_REG_WDATA = 8'h18;
	localparam logic [7:0] CEB_REG_STAT = 8'h1c;
	localparam logic [7:0] CEB_REG_RDATA = 8'h20;
	// ------------------------------------------------------------
	// ctrl fields
	// ------------------------------------------------------------
	localparam int CEB_CTRL_EN_BIT = 0;
	localparam int CEB_CTRL_ATS_PF_BIT = 1;
	localparam int CEB_CTRL_ATS_VF_BIT = 2;
	localparam int CEB_CTRL_LAT_LSB = 4;
	localparam int CEB_LAT_W = 3;
	// req fields: address [11:2] as dword index, bit 16 write, bit 17 vf, bits 23:20 byte enables
	localparam int CEB_REQ_ADDR_LSB = 0;
	localparam int CEB_ADDR_W = 10;
	localparam int CEB_REQ_WR_BIT = 16;
	localparam int CEB_REQ_VF_BIT = 17;
	localparam int CEB_REQ_BE_LSB = 20;
	// stat fields
	localparam int CEB_STAT_BUSY_BIT = 0;
	localparam int CEB_STAT_TMO_BIT = 1;
	localparam int CEB_STAT_CPL_LSB = 4;
	// ------------------------------------------------------------
	// reset values and limits
	// ------------------------------------------------------------
	localparam logic [2:0] CEB_LAT_RST = 3'h1;
	localparam logic [2:0] CEB_LAT_MIN = 3'h1;
	localparam logic [9:0] CEB_STD_PTR_RST = 10'h000;
	localparam logic [9:0] CEB_EXT_PTR_RST = 10'h000;
	localparam logic [9:0] CEB_EXT_PTR_MIN = 10'h100;
	localparam logic [2:0] CEB_CPL_OK = 3'h0;
	localparam logic [2:0] CEB_CPL_TMO = 3'h0;
	typedef enum logic [1:0] {CEB_IDLE, CEB_WAIT, CEB_DONE} ceb_state_type;
endpackage

/* rtl/ceb_timer.sv */
// ceb_timer: counts cycles a request waits for acknowledge
// assumes start pulses only while the request is idle
`timescale 1ns/10ps
module ceb_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [ceb_pkg::CEB_LAT_W-1:0] limit_i,
	output logic expired_o
);
	import ceb_pkg::*;
	logic [CEB_LAT_W-1:0] cnt_q;
	logic [CEB_LAT_W-1:0] cnt_d;
	logic [CEB_LAT_W-1:0] lim_w;
	// a zero setting would wrap to the longest wait, so it is lifted to one
	assign lim_w = (limit_i < CEB_LAT_MIN) ? CEB_LAT_MIN : limit_i;
	assign cnt_d = run_i ? CEB_LAT_W'(cnt_q + 1'b1) : '0;
	assign expired_o = run_i && (cnt_q >= CEB_LAT_W'(lim_w - 1'b1));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // ceb_timer

/* rtl/ceb_bridge.sv */
// ceb_bridge: configuration extension bus bridge with wishbone register port
// assumes a classic wishbone master and user capability logic on clk_i
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module ceb_bridge (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic config_extension_bus_req_o,
	output logic config_extension_bus_wr_o,
	output logic config_extension_bus_vf_o,
	output logic [ceb_pkg::CEB_ADDR_W-1:0] config_extension_bus_addr_o,
	output logic [3:0] config_extension_bus_be_o,
	output logic [31:0] config_extension_bus_wdata_o,
	input wire logic config_extension_bus_ack_i,
	input wire logic [31:0] config_extension_bus_rdata_i,
	output logic [ceb_pkg::CEB_ADDR_W-1:0] std_next_ptr_o,
	output logic [ceb_pkg::CEB_ADDR_W-1:0] ext_next_ptr_o,
	output logic ats_pf_present_o,
	output logic ats_vf_present_o
);
	import ceb_pkg::*;
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ceb_state_type state_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic en_q, ats_pf_q, ats_vf_q;
	logic [CEB_LAT_W-1:0] lat_q;
	logic [CEB_ADDR_W-1:0] pf_std_q, pf_ext_q, vf_std_q, vf_ext_q;
	logic [31:0] req_q, wdata_q, rdata_q;
	logic tmo_q;
	logic [2:0] cpl_q;
	logic expired_w;
	logic bus_req_w, wr_w, start_w, user_ack_w;
	logic [31:0] rd_mux_w;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [CEB_ADDR_W-1:0] ext_floor(input logic [CEB_ADDR_W-1:0] p);
		return (p != CEB_EXT_PTR_RST && p < CEB_EXT_PTR_MIN) ? CEB_EXT_PTR_MIN : p;
	endfunction

	// ------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------
	// single-cycle answer: ack the cycle after the strobe, then drop
	assign bus_req_w = cyc_i && stb_i && !ack_q;
	assign wr_w = bus_req_w && we_i;
	assign start_w = wr_w && (adr_i == CEB_REG_REQ) && sel_i[0] && en_q && (state_q == CEB_IDLE);
	assign user_ack_w = (state_q == CEB_WAIT) && config_extension_bus_ack_i;

	always_comb begin
		unique case (adr_i)
			CEB_REG_CTRL: rd_mux_w = {25'h000_0000, lat_q, 1'b0, ats_vf_q, ats_pf_q, en_q};
			CEB_REG_PF_STD: rd_mux_w = {22'h00_0000, pf_std_q};
			CEB_REG_PF_EXT: rd_mux_w = {22'h00_0000, pf_ext_q};
			CEB_REG_VF_STD: rd_mux_w = {22'h00_0000, vf_std_q};
			CEB_REG_VF_EXT: rd_mux_w = {22'h00_0000, vf_ext_q};
			CEB_REG_REQ: rd_mux_w = req_q;
			CEB_REG_WDATA: rd_mux_w = wdata_q;
			CEB_REG_STAT: rd_mux_w = {25'h000_0000, cpl_q, 2'b00, tmo_q, state_q != CEB_IDLE};
			CEB_REG_RDATA: rd_mux_w = rdata_q;
			default: rd_mux_w = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req_w;
			dat_q <= (bus_req_w && !we_i) ? rd_mux_w : dat_q;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
			ats_pf_q <= 1'b0;
			ats_vf_q <= 1'b0;
			lat_q <= CEB_LAT_RST;
			pf_std_q <= CEB_STD_PTR_RST;
			pf_ext_q <= CEB_EXT_PTR_RST;
			vf_std_q <= CEB_STD_PTR_RST;
			vf_ext_q <= CEB_EXT_PTR_RST;
			wdata_q <= 32'h0000_0000;
		end else if (wr_w) begin
			unique case (adr_i)
				CEB_REG_CTRL: if (sel_i[0]) begin
					en_q <= dat_i[CEB_CTRL_EN_BIT];
					ats_pf_q <= dat_i[CEB_CTRL_ATS_PF_BIT];
					ats_vf_q <= dat_i[CEB_CTRL_ATS_VF_BIT];
					lat_q <= (dat_i[CEB_CTRL_LAT_LSB +: CEB_LAT_W] < CEB_LAT_MIN) ? CEB_LAT_MIN
						: dat_i[CEB_CTRL_LAT_LSB +: CEB_LAT_W];
				end
				CEB_REG_PF_STD: pf_std_q <= CEB_ADDR_W'(merge({22'h00_0000, pf_std_q}, dat_i, sel_i));
				CEB_REG_VF_STD: vf_std_q <= CEB_ADDR_W'(merge({22'h00_0000, vf_std_q}, dat_i, sel_i));
				CEB_REG_PF_EXT: pf_ext_q <= ext_floor(CEB_ADDR_W'(merge({22'h00_0000, pf_ext_q}, dat_i, sel_i)));
				CEB_REG_VF_EXT: vf_ext_q <= ext_floor(CEB_ADDR_W'(merge({22'h00_0000, vf_ext_q}, dat_i, sel_i)));
				CEB_REG_WDATA: wdata_q <= merge(wdata_q, dat_i, sel_i);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// extension request engine
	// ------------------------------------------------------------
	ceb_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(state_q == CEB_WAIT),
		.limit_i(lat_q),
		.expired_o(expired_w)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= CEB_IDLE;
			req_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			tmo_q <= 1'b0;
			cpl_q <= CEB_CPL_OK;
		end else begin
			unique case (state_q)
				CEB_IDLE: if (start_w) begin
					req_q <= dat_i;
					state_q <= CEB_WAIT;
				end
				CEB_WAIT: if (user_ack_w) begin
					// ack ends request (ack wins over a same-cycle timeout)
					rdata_q <= req_q[CEB_REQ_WR_BIT] ? 32'h0000_0000 : config_extension_bus_rdata_i;
					tmo_q <= 1'b0;
					cpl_q <= CEB_CPL_OK;
					state_q <= CEB_DONE;
				end else if (expired_w) begin
					rdata_q <= 32'h0000_0000;
					cpl_q <= CEB_CPL_TMO;
					tmo_q <= 1'b1;
					state_q <= CEB_DONE;
				end
				CEB_DONE: state_q <= CEB_IDLE;
				default: state_q <= CEB_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_extension_bus_req_o <= 1'b0;
			config_extension_bus_wr_o <= 1'b0;
			config_extension_bus_vf_o <= 1'b0;
			config_extension_bus_addr_o <= '0;
			config_extension_bus_be_o <= 4'h0;
			config_extension_bus_wdata_o <= 32'h0000_0000;
		end else if (start_w) begin
			config_extension_bus_req_o <= 1'b1;
			config_extension_bus_wr_o <= dat_i[CEB_REQ_WR_BIT];
			config_extension_bus_vf_o <= dat_i[CEB_REQ_VF_BIT];
			config_extension_bus_addr_o <= dat_i[CEB_REQ_ADDR_LSB +: CEB_ADDR_W];
			config_extension_bus_be_o <= dat_i[CEB_REQ_BE_LSB +: 4];
			config_extension_bus_wdata_o <= wdata_q;
		end else if (user_ack_w || expired_w) begin
			config_extension_bus_req_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			std_next_ptr_o <= CEB_STD_PTR_RST;
			ext_next_ptr_o <= CEB_EXT_PTR_RST;
			ats_pf_present_o <= 1'b0;
			ats_vf_present_o <= 1'b0;
		end else begin
			// pointer select per function type; zero ends the list when the option is off
			std_next_ptr_o <= !en_q ? CEB_STD_PTR_RST : (req_q[CEB_REQ_VF_BIT] ? vf_std_q : pf_std_q);
			ext_next_ptr_o <= !en_q ? CEB_EXT_PTR_RST : (req_q[CEB_REQ_VF_BIT] ? vf_ext_q : pf_ext_q);
			ats_pf_present_o <= ats_pf_q;
			ats_vf_present_o <= ats_vf_q;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
endmodule // ceb_bridge

/* tb/ceb_props.sv */
// ceb_props: port assertions for ceb_bridge
// assumes bind into ceb_bridge, one clock, sync reset
`timescale 1ns/10ps
module ceb_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic ack_o,
	input wire logic config_extension_bus_req_o,
	input wire logic [ceb_pkg::CEB_ADDR_W-1:0] config_extension_bus_addr_o,
	input wire logic config_extension_bus_ack_i,
	input wire logic [ceb_pkg::CEB_ADDR_W-1:0] ext_next_ptr_o
);
	import ceb_pkg::*;
	logic rq;
	logic ak;
	assign rq = config_extension_bus_req_o;
	assign ak = config_extension_bus_ack_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------
	// properties
	// ----------------
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held past one cycle");
	a_wb_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus access not answered next cycle");
	a_req_cause: assert property ($rose(rq) |-> $past(cyc_i && stb_i && we_i && adr_i == CEB_REG_REQ))
		else $error("request without request write");
	a_req_hold: assert property (rq && !ak |=> !rq || $stable(config_extension_bus_addr_o))
		else $error("request address moved while waiting");
	a_ack_ends: assert property (rq && ak |=> !rq)
		else $error("request kept after acknowledge");
	a_tmo_bound: assert property ($rose(rq) |-> ##[1:7] !rq)
		else $error("request outlived longest timeout");
	a_ext_floor: assert property (ext_next_ptr_o != 10'h000 |-> ext_next_ptr_o >= CEB_EXT_PTR_MIN)
		else $error("extended pointer below extended region");
endmodule // ceb_props
bind ceb_bridge ceb_props chk_u (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.we_i(we_i),
	.adr_i(adr_i),
	.ack_o(ack_o),
	.config_extension_bus_req_o(config_extension_bus_req_o),
	.config_extension_bus_addr_o(config_extension_bus_addr_o),
	.config_extension_bus_ack_i(config_extension_bus_ack_i),
	.ext_next_ptr_o(ext_next_ptr_o)
);

/* tb/ceb_user_model.sv */
// ceb_user_model: user capability logic on the extension bus
// assumes one held request at a time; dly_i 15 never answers
`timescale 1ns/10ps
module ceb_user_model (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [9:0] addr_i,
	input wire logic [3:0] dly_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	logic [3:0] cnt_q;
	logic [31:0] val;
	assign ack_o = req_i && cnt_q == dly_i;
	// one shared space, no per-function data
	assign val = {22'h0, addr_i} ^ 32'h5a5a_0000;
	// data is invalid outside ack, so show its inverse
	assign rdata_o = ack_o ? val : ~val;
	always_ff @(posedge clk_i) begin
		if (!req_i)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'he)
			cnt_q <= cnt_q + 4'h1;
	end
endmodule // ceb_user_model

/* tb/testbench.sv */
// testbench: register-level tests of ceb_bridge
// assumes ceb_user_model on the extension side
`timescale 1ns/10ps
module testbench;
	import ceb_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hf, dly = 4'h0, be;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, rdata, q, wdata;
	logic ack_o, req, wr, vf, uack, ats_pf, ats_vf;
	logic [9:0] addr, std_p, ext_p;
	int n_fail = 0, cmp_count = 0, cyc_n = 0, hi_n = 0, h0;
	logic [15:0] s_fld;
	logic [31:0] s_wd;
	always #50 clk_i = ~clk_i;
	ceb_bridge dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .config_extension_bus_req_o(req),
		.config_extension_bus_wr_o(wr), .config_extension_bus_vf_o(vf), .config_extension_bus_addr_o(addr),
		.config_extension_bus_be_o(be), .config_extension_bus_wdata_o(wdata), .config_extension_bus_ack_i(uack),
		.config_extension_bus_rdata_i(rdata), .std_next_ptr_o(std_p), .ext_next_ptr_o(ext_p),
		.ats_pf_present_o(ats_pf), .ats_vf_present_o(ats_vf));
	ceb_user_model usr_u (.clk_i(clk_i), .req_i(req), .addr_i(addr), .dly_i(dly), .ack_o(uack), .rdata_o(rdata));
	// ----------------
	// tasks
	// ----------------
	task end_sim;
		if (n_fail == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		hi_n <= hi_n + int'(req === 1'b1);
		if (cyc_n > 3000) begin
			n_fail++;
			end_sim();
		end
	end
	// fields seen while the request stands
	always @(posedge clk_i) begin
		if (req === 1'b1) begin
			s_fld <= {wr, vf, be, addr};
			s_wd <= wdata;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic run(input logic [31:0] r, input logic [3:0] d);
		dly <= d;
		wb(1'b1, CEB_REG_REQ, r);
		do wb(1'b0, CEB_REG_STAT, 32'h0); while (q[0] !== 1'b0);
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, CEB_REG_CTRL, 32'h0);
		chk("ctrl", 32'h0000_0010, q);
		for (int i = 1; i < 5; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0);
			chk("ptr", 32'h0, q);
		end
		wb(1'b1, 8'h24, 32'hffff_ffff);
		wb(1'b0, 8'h24, 32'h0);
		chk("unmapped", 32'h0, q);
		h0 = hi_n;
		run(32'h0000_0110, 4'h0);
		chk("req off", h0, hi_n);
		wb(1'b1, CEB_REG_CTRL, 32'h0000_0033);
		chk("ats", 32'h1, 32'({ats_vf, ats_pf}));
		wb(1'b1, CEB_REG_PF_STD, 32'h0000_001b);
		wb(1'b1, CEB_REG_PF_EXT, 32'h0000_0050);
		wb(1'b1, CEB_REG_VF_STD, 32'h0000_0040);
		wb(1'b1, CEB_REG_VF_EXT, 32'h0000_0123);
		wb(1'b0, CEB_REG_PF_EXT, 32'h0);
		chk("ext floor", 32'h0000_0100, q);
		run(32'h0000_0110, 4'h0);
		wb(1'b0, CEB_REG_RDATA, 32'h0);
		chk("rdata", 32'h5a5a_0110, q);
		chk("pf ptrs", 32'h0000_6d00, 32'({std_p, ext_p}));
		run(32'h0002_0120, 4'h2);
		chk("tie stat", 32'h0, q);
		chk("vf fields", {16'h0000, 1'b0, 1'b1, 4'h0, 10'h120}, {16'h0000, s_fld});
		wb(1'b0, CEB_REG_RDATA, 32'h0);
		chk("tie rdata", 32'h5a5a_0120, q);
		chk("vf ptrs", 32'h0001_0123, 32'({std_p, ext_p}));
		wb(1'b1, CEB_REG_CTRL, 32'h0000_0057);
		chk("ats both", 32'h3, 32'({ats_vf, ats_pf}));
		for (int l = 1; l < 8; l++) begin
			wb(1'b1, CEB_REG_CTRL, 32'(l << 4 | 1));
			h0 = hi_n;
			run(32'h0000_0130, 4'hf);
			chk("req len", h0 + l, hi_n);
			chk("tmo stat", 32'h0000_0002, q);
			wb(1'b0, CEB_REG_RDATA, 32'h0);
			chk("tmo rdata", 32'h0, q);
		end
		h0 = hi_n;
		wb(1'b1, CEB_REG_REQ, 32'h0000_0150);
		run(32'h0000_0160, 4'hf);
		chk("busy refuse", h0 + 7, hi_n);
		chk("busy fields", {16'h0000, 1'b0, 1'b0, 4'h0, 10'h150}, {16'h0000, s_fld});
		wb(1'b1, CEB_REG_WDATA, 32'hcafe_f00d);
		run(32'h00f1_0140, 4'h1);
		chk("wr fields", {16'h0000, 1'b1, 1'b0, 4'hf, 10'h140}, {16'h0000, s_fld});
		chk("wr wdata", 32'hcafe_f00d, s_wd);
		wb(1'b0, CEB_REG_RDATA, 32'h0);
		chk("wr rdata", 32'h0, q);
		end_sim();
	end
endmodule // testbench
